//--- hdl/fsp_protect.sv
// Overview of operation
// RULE1: range code bits live at S4..S2, changed only by status writes.
// RULE2: range code resets to zero, nothing protected.
// RULE3: top/bottom select 0 protects from top, 1 from bottom; default 0.
// RULE4: granule select 1 counts 4KB sectors, 0 counts 64KB blocks.
// RULE5: invert bit at S12 flips protected and unprotected parts.
// RULE6: program or erase touching protected addresses is refused.
// RULE7: 64KB granule codes protect none, 1/32..1/2, or all 2MB.
// RULE8: 4KB granule codes 001..011 protect top 4KB, 8KB, 16KB.
// RULE9: lock mode bits at S8 and S7 choose status write locking.
// RULE10: lock mode 00 ignores the pin; write needs the enable latch.
// RULE11: lock mode 01 refuses status writes while the pin is low.
// RULE12: lock mode 10 blocks writes until power cycle, then reads 00.
// RULE13: lock mode 11 refuses every status write forever.
// RULE14: output strength 00/01/10/11 selects 100/75/50/25 percent.
// RULE15: paused flag S11 set by 75h, cleared by 7Ah or power cycle.
// RULE16: fail flag set on failed operation, never on refused one.
// RULE17: security lock S10 only goes 0 to 1, then stays.
// RULE18: quad bit S9 turns pin functions into data lines 2 and 3.
// RULE19: enter four-wire mode 38h ignored unless quad bit is set.
// RULE20: in four-wire mode a status write cannot clear the quad bit.
// RULE21: host must not set quad bit with pins tied to rails.
// RULE22: host sends write enable before every status write.
// RULE23: protection decode is combinational from the stored bits.
module fsp_protect (
   input wire logic lnk_clk,
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic write_protect_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_wide,
   input wire logic [15:0] cmd_data,
   input wire logic [fsp_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic nv_load,
   input wire logic [15:0] nv_image,
   input wire logic op_done,
   input wire logic op_fail,
   output logic [15:0] status_word,
   output logic [1:0] drive_strength,
   output logic quad_pins_enable,
   output logic four_wire_command_mode,
   output logic security_regs_locked,
   output logic op_refused,
   output logic op_start,
   output logic [7:0] op_code,
   output logic [fsp_pkg::ADDR_W-1:0] op_addr_first,
   output logic [fsp_pkg::ADDR_W-1:0] op_addr_last
);
   import fsp_pkg::*;

   // ==========================================================
   // state of both domains
   // ==========================================================
   typedef struct packed {
      logic [15:0] status;
      logic four_wire;
      logic wp_s1;
      logic wp_s2;
      logic done_s1;
      logic done_s2;
      logic done_seen;
      logic req_tgl;
      logic refused;
      logic [7:0] code;
      logic [20:0] lo;
      logic [20:0] hi;
   } fsp_lnk_s;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic done_tgl;
      logic fail;
      logic start;
      logic [7:0] code;
      logic [20:0] lo;
      logic [20:0] hi;
   } fsp_sys_s;

   fsp_lnk_s lnk_reg;
   fsp_lnk_s lnk_next;
   fsp_sys_s sys_reg;
   fsp_sys_s sys_next;

   // ==========================================================
   // helpers
   // ==========================================================
   // address span touched by a program or erase instruction
   function automatic logic [41:0] op_span(input logic [7:0] code, input logic [20:0] addr);
      logic [20:0] sz;
      logic [20:0] base;
      sz = SZ_PAGE;
      case (code)
         OP_ERASE_4K: sz = SZ_4K;
         OP_ERASE_32K: sz = SZ_32K;
         OP_ERASE_64K: sz = SZ_64K;
         default: sz = SZ_PAGE;
      endcase
      // erase and page program act on the aligned unit around addr
      base = addr & ~(sz - 21'h000001);
      if (code == OP_ERASE_ALL || code == OP_ERASE_ALL_ALT) begin
         op_span = {21'h000000, ARRAY_LAST};
      end else begin
         op_span = {base, base + (sz - 21'h000001)};
      end
   endfunction

   // true when any address in [lo, hi] is read-only under st
   function automatic logic is_blocked(input logic [15:0] st, input logic [20:0] lo,
                                       input logic [20:0] hi);
      logic [2:0] code;
      logic none;
      logic [20:0] sz;
      logic [20:0] plo;
      logic [20:0] phi;
      code = st[B_RANGE_HI:B_RANGE_LO];
      none = 1'b0;
      sz = ARRAY_LAST;
      // RULE7: block granule codes
      if (code == 3'h0) begin
         none = 1'b1;
      end else if (code[2:1] == 2'h3) begin
         sz = ARRAY_LAST;
      // RULE4: sector granule
      end else if (st[B_GRANULE]) begin
         // RULE8: 4KB, 8KB, 16KB, then 32KB
         if (code[2]) begin
            sz = SZ_32K;
         end else begin
            sz = SZ_4K << (code[1:0] - 2'h1);
         end
      end else begin
         sz = SZ_64K << (code - 3'h1);
      end
      // RULE3: top or bottom anchor
      if (code[2:1] == 2'h3) begin
         plo = 21'h000000;
         phi = ARRAY_LAST;
      end else if (st[B_TOP_BOTTOM]) begin
         plo = 21'h000000;
         phi = sz - 21'h000001;
      end else begin
         plo = ARRAY_LAST - (sz - 21'h000001);
         phi = ARRAY_LAST;
      end
      // RULE5: inverted map, only the decoded range stays writable
      if (st[B_INVERT]) begin
         is_blocked = none || !(lo >= plo && hi <= phi);
      end else begin
         is_blocked = !none && (lo <= phi && hi >= plo);
      end
   endfunction

   // ==========================================================
   // link side: status word, instruction effects
   // ==========================================================
   logic [41:0] span;
   logic blocked;
   logic sr_ok;
   logic wp_high;
   logic [1:0] lock;

   // RULE23: span and decode follow the stored bits with no latency
   assign span = op_span(cmd_code, cmd_addr);
   assign blocked = is_blocked(lnk_reg.status, span[41:21], span[20:0]);
   assign lock = {lnk_reg.status[B_LOCK_HI], lnk_reg.status[B_LOCK_LO]};
   // with the quad bit set the pin is a data line, so it cannot lock
   assign wp_high = lnk_reg.wp_s2 || lnk_reg.status[B_QUAD];

   // write permission for the status word
   always_comb begin
      sr_ok = 1'b0;
      case (lock)
         // RULE10: pin ignored
         LOCK_SOFT: sr_ok = lnk_reg.status[B_WEL];
         // RULE11: pin low locks
         LOCK_PIN: sr_ok = lnk_reg.status[B_WEL] && wp_high;
         // RULE12: locked until power cycle
         LOCK_POWER: sr_ok = 1'b0;
         // RULE13: locked for good
         LOCK_OTP: sr_ok = 1'b0;
         default: sr_ok = 1'b0;
      endcase
   end

   // next state of the link domain
   always_comb begin
      logic [15:0] nw;
      nw = lnk_reg.status;
      lnk_next = lnk_reg;
      lnk_next.refused = 1'b0;
      lnk_next.wp_s1 = write_protect_n;
      lnk_next.wp_s2 = lnk_reg.wp_s1;
      lnk_next.done_s1 = sys_reg.done_tgl;
      lnk_next.done_s2 = lnk_reg.done_s1;
      // operation finished in the array engine
      if (lnk_reg.done_s2 != lnk_reg.done_seen) begin
         lnk_next.done_seen = lnk_reg.done_s2;
         lnk_next.status[B_BUSY] = 1'b0;
         // RULE16: fail result held stable by the engine side
         lnk_next.status[B_FAIL] = sys_reg.fail;
      end
      if (nv_load) begin
         // power-up restore of the stored bits
         lnk_next.status = nv_image;
         lnk_next.status[B_BUSY] = 1'b0;
         lnk_next.status[B_WEL] = 1'b0;
         lnk_next.status[B_FAIL] = 1'b0;
         // RULE15: paused flag does not survive power cycle
         lnk_next.status[B_PAUSED] = 1'b0;
         lnk_next.four_wire = 1'b0;
         // RULE12: power lock-down returns to software mode
         if ({nv_image[B_LOCK_HI], nv_image[B_LOCK_LO]} == LOCK_POWER) begin
            lnk_next.status[B_LOCK_HI] = 1'b0;
            lnk_next.status[B_LOCK_LO] = 1'b0;
         end
      end else if (cmd_valid && lnk_reg.status[B_BUSY]) begin
         // while busy only suspend and resume are heard
         // RULE15: suspend and resume
         if (cmd_code == OP_SUSPEND) begin
            lnk_next.status[B_PAUSED] = 1'b1;
         end else if (cmd_code == OP_RESUME) begin
            lnk_next.status[B_PAUSED] = 1'b0;
         end
      end else if (cmd_valid) begin
         case (cmd_code)
            OP_WREN: lnk_next.status[B_WEL] = 1'b1;
            OP_WRDI: lnk_next.status[B_WEL] = 1'b0;
            OP_RESUME: lnk_next.status[B_PAUSED] = 1'b0;
            // RULE19: quad bit must already be set
            OP_FOUR_WIRE_ON: lnk_next.four_wire = lnk_reg.status[B_QUAD];
            OP_FOUR_WIRE_OFF: lnk_next.four_wire = 1'b0;
            OP_WRSR_LOW, OP_WRSR_HIGH: begin
               // RULE1: 31h takes the high byte; 01h the low byte, or both bytes when wide
               if (cmd_code == OP_WRSR_HIGH) begin
                  nw[15:8] = cmd_data[7:0];
               end else if (cmd_wide) begin
                  nw = cmd_data;
               end else begin
                  nw[7:0] = cmd_data[7:0];
               end
               // RULE22: host enables writes first, latch drops after
               lnk_next.status[B_WEL] = 1'b0;
               // RULE9: lock bits and all writable fields taken
               if (sr_ok) begin
                  lnk_next.status[B_RANGE_HI:B_RANGE_LO] = nw[B_RANGE_HI:B_RANGE_LO];
                  lnk_next.status[B_TOP_BOTTOM] = nw[B_TOP_BOTTOM];
                  lnk_next.status[B_GRANULE] = nw[B_GRANULE];
                  lnk_next.status[B_LOCK_LO] = nw[B_LOCK_LO];
                  lnk_next.status[B_LOCK_HI] = nw[B_LOCK_HI];
                  lnk_next.status[B_INVERT] = nw[B_INVERT];
                  lnk_next.status[B_DRV_HI:B_DRV_LO] = nw[B_DRV_HI:B_DRV_LO];
                  // RULE17: one-time lock
                  lnk_next.status[B_SEC_LOCK] = lnk_reg.status[B_SEC_LOCK] | nw[B_SEC_LOCK];
                  // RULE20: quad bit held while in four-wire mode
                  lnk_next.status[B_QUAD] = nw[B_QUAD] | lnk_reg.four_wire;
               end
            end
            OP_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_ERASE_ALL,
            OP_ERASE_ALL_ALT: begin
               if (lnk_reg.status[B_WEL]) begin
                  lnk_next.status[B_WEL] = 1'b0;
                  // RULE6: refuse, fail flag untouched
                  if (blocked) begin
                     lnk_next.refused = 1'b1;
                  end else begin
                     // span held in flops until the engine answers
                     lnk_next.status[B_BUSY] = 1'b1;
                     lnk_next.status[B_FAIL] = 1'b0;
                     lnk_next.code = cmd_code;
                     lnk_next.lo = span[41:21];
                     lnk_next.hi = span[20:0];
                     lnk_next.req_tgl = ~lnk_reg.req_tgl;
                  end
               end
            end
            default: lnk_next.status = lnk_reg.status;
         endcase
      end
   end

   // RULE2: factory defaults at power-up
   always_ff @(posedge lnk_clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk_reg <= '0;
      end else if (clk_en) begin
         lnk_reg <= lnk_next;
      end
   end

   // ==========================================================
   // engine side: request handoff and result capture
   // ==========================================================
   // the toggle crosses through two flops; the span words are
   // stable for the whole request, so they are sampled directly
   always_comb begin
      sys_next = sys_reg;
      sys_next.start = 1'b0;
      sys_next.req_s1 = lnk_reg.req_tgl;
      sys_next.req_s2 = sys_reg.req_s1;
      if (sys_reg.req_s2 != sys_reg.req_seen) begin
         sys_next.req_seen = sys_reg.req_s2;
         sys_next.start = 1'b1;
         sys_next.code = lnk_reg.code;
         sys_next.lo = lnk_reg.lo;
         sys_next.hi = lnk_reg.hi;
      end
      // RULE16: outcome of the last operation
      if (op_done) begin
         sys_next.fail = op_fail;
         sys_next.done_tgl = ~sys_reg.done_tgl;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reg <= '0;
      end else if (clk_en) begin
         sys_reg <= sys_next;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign status_word = lnk_reg.status;
   // RULE14: strength code 0..3 means 100, 75, 50, 25 percent
   assign drive_strength = lnk_reg.status[B_DRV_HI:B_DRV_LO];
   // RULE18: pins become data lines 2 and 3
   assign quad_pins_enable = lnk_reg.status[B_QUAD];
   assign four_wire_command_mode = lnk_reg.four_wire;
   assign security_regs_locked = lnk_reg.status[B_SEC_LOCK];
   assign op_refused = lnk_reg.refused;
   assign op_start = sys_reg.start;
   assign op_code = sys_reg.code;
   assign op_addr_first = sys_reg.lo;
   assign op_addr_last = sys_reg.hi;

endmodule

//--- shared/fsp_pkg.sv
package fsp_pkg;

   // ==========================================================
   // array geometry
   // ==========================================================
   localparam int ADDR_W = 21;
   localparam logic [20:0] ARRAY_LAST = 21'h1fffff;
   localparam logic [20:0] SZ_PAGE = 21'h000100;
   localparam logic [20:0] SZ_4K = 21'h001000;
   localparam logic [20:0] SZ_32K = 21'h008000;
   localparam logic [20:0] SZ_64K = 21'h010000;

   // ==========================================================
   // instruction codes seen by the protection logic
   // ==========================================================
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_WRSR_LOW = 8'h01;
   localparam logic [7:0] OP_WRSR_HIGH = 8'h31;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_FOUR_WIRE_ON = 8'h38;
   localparam logic [7:0] OP_FOUR_WIRE_OFF = 8'hff;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hd8;
   localparam logic [7:0] OP_ERASE_ALL = 8'hc7;
   localparam logic [7:0] OP_ERASE_ALL_ALT = 8'h60;

   // ==========================================================
   // status word bit positions
   // ==========================================================
   localparam int B_BUSY = 0;
   localparam int B_WEL = 1;
   localparam int B_RANGE_LO = 2;
   localparam int B_RANGE_HI = 4;
   localparam int B_TOP_BOTTOM = 5;
   localparam int B_GRANULE = 6;
   localparam int B_LOCK_LO = 7;
   localparam int B_LOCK_HI = 8;
   localparam int B_QUAD = 9;
   localparam int B_SEC_LOCK = 10;
   localparam int B_PAUSED = 11;
   localparam int B_INVERT = 12;
   localparam int B_DRV_LO = 13;
   localparam int B_DRV_HI = 14;
   localparam int B_FAIL = 15;

   // ==========================================================
   // lock modes and reset values
   // ==========================================================
   localparam logic [1:0] LOCK_SOFT = 2'h0;
   localparam logic [1:0] LOCK_PIN = 2'h1;
   localparam logic [1:0] LOCK_POWER = 2'h2;
   localparam logic [1:0] LOCK_OTP = 2'h3;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

endpackage

//--- sim/fsp_host_model.sv
// ==========================================================
// host controller: one instruction per issue call, lines scrambled when idle
module fsp_host_model (
   input wire logic lnk_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic cmd_wide,
   output logic [15:0] cmd_data,
   output logic [fsp_pkg::ADDR_W-1:0] cmd_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   logic wide_sel;
   initial begin
      wide_sel = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wide = 1'b0;
      cmd_data = 16'h0000;
      cmd_addr = '0;
   end
   // held across exactly one taking edge, then inverted so stale data never matches
   task automatic issue(input logic [7:0] code, input logic [15:0] data,
                        input logic [ADDR_W-1:0] addr);
      @(posedge lnk_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_wide = wide_sel;
      cmd_data = data;
      cmd_addr = addr;
      @(posedge lnk_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_wide = ~wide_sel;
      cmd_data = ~data;
      cmd_addr = ~addr;
   endtask
   task automatic write_status(input logic [15:0] data);
      issue(OP_WREN, 16'h0000, '0);
      issue(OP_WRSR_LOW, data, '0);
   endtask
   // write enable first, then a byte-wide status write
   task automatic write_narrow(input logic [7:0] code, input logic [15:0] data);
      wide_sel = 1'b0;
      issue(OP_WREN, 16'h0000, '0);
      issue(code, data, '0);
      wide_sel = 1'b1;
   endtask
endmodule

//--- sim/fsp_protect_bench.sv
// ==========================================================
// protection bench
module fsp_protect_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   typedef struct packed {logic [15:0] sd; logic [20:0] a; logic p;} fsp_case_s;
   localparam fsp_case_s CASES [15] = '{'{16'h0004, 21'h1f0000, 1}, '{16'h0004, 21'h1ef000, 0},
      '{16'h0024, 21'h00f000, 1}, '{16'h0024, 21'h010000, 0}, '{16'h0014, 21'h100000, 1},
      '{16'h0014, 21'h0ff000, 0}, '{16'h0018, 21'h000000, 1}, '{16'h0000, 21'h1ff000, 0},
      '{16'h0044, 21'h1ff000, 1}, '{16'h0044, 21'h1fe000, 0}, '{16'h004c, 21'h1fc000, 1},
      '{16'h004c, 21'h1fb000, 0}, '{16'h1004, 21'h1f0000, 0}, '{16'h1004, 21'h1ef000, 1},
      '{16'h1000, 21'h000000, 1}};
   logic sys_clk, lnk_clk, rst_n, clk_en, write_protect_n;
   logic nv_load, op_done, op_fail, chk_go = 0, fail_next = 0;
   logic [15:0] nv_image;
   logic cmd_valid, cmd_wide, quad_pins_enable, four_wire_command_mode;
   logic security_regs_locked, op_refused, op_start;
   logic [7:0] cmd_code, op_code;
   logic [15:0] cmd_data, status_word;
   logic [1:0] drive_strength;
   logic [ADDR_W-1:0] cmd_addr, op_addr_first, op_addr_last;
   logic [17:0] note_q[$];
   logic [17:0] mask_q[$];
   logic [49:0] addr_q[$];
   int err_count = 0, compares = 0, cycles = 0;
   always #50 sys_clk = ~sys_clk;
   always #16 lnk_clk = ~lnk_clk;
   fsp_protect DUT (.lnk_clk, .sys_clk, .rst_n, .clk_en, .write_protect_n, .cmd_valid, .cmd_code,
      .cmd_wide, .cmd_data, .cmd_addr, .nv_load, .nv_image, .op_done, .op_fail, .status_word,
      .drive_strength, .quad_pins_enable, .four_wire_command_mode, .security_regs_locked,
      .op_refused, .op_start, .op_code, .op_addr_first, .op_addr_last);
   fsp_host_model host (.lnk_clk, .cmd_valid, .cmd_code, .cmd_wide, .cmd_data, .cmd_addr);
   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // note the expectation; the monitor compares it at the next link edge
   task automatic expect_st(input logic [17:0] mask, input logic [17:0] val);
      note_q.push_back(val & mask);
      mask_q.push_back(mask);
      chk_go = 1;
      @(posedge lnk_clk);
      #1;
      chk_go = 0;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && status_word[0] !== 1'b0; i++) @(posedge lnk_clk);
      #1;
   endtask
   task automatic power_cycle(input logic [15:0] img);
      nv_image = img;
      @(posedge lnk_clk);
      #1;
      nv_load = 1;
      @(posedge lnk_clk);
      #1;
      nv_load = 0;
   endtask
   // status monitor: oldest note against what the outputs show now
   always @(posedge lnk_clk) begin
      if (chk_go) cmp("status", 64'(note_q.pop_front()),
         64'({four_wire_command_mode, op_refused, status_word} & mask_q.pop_front()));
   end
   // engine stand-in: check the started range, finish three cycles later
   initial begin
      op_done = 1'b0;
      op_fail = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (op_start) begin
            cmp("op range", 64'(addr_q.pop_front()),
               64'({op_code, op_addr_first, op_addr_last}));
            repeat (3) @(posedge sys_clk);
            #1;
            op_fail = fail_next;
            op_done = 1;
            @(posedge sys_clk);
            #1;
            op_done = 0;
         end
      end
   end
   // hang guard, far beyond the expected run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      logic [15:0] d;
      sys_clk = 1'b0;
      lnk_clk = 1'b0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      write_protect_n = 1'b1;
      nv_load = 1'b0;
      nv_image = 16'h0000;
      void'($urandom(94));
      repeat (2) @(posedge sys_clk);
      #1;
      rst_n = 1;
      expect_st(18'h3ffff, 18'h0);
      for (int i = 0; i < 4; i++) begin
         d = (16'($urandom()) & 16'h107c) | {1'b0, 2'(i), 13'h0};
         host.write_status(d);
         expect_st(18'h3ffff, {2'b00, d});
      end
      // frozen clock enable: enable and write must both be lost
      clk_en = 1'b0;
      host.write_status(16'h0000);
      clk_en = 1'b1;
      expect_st(18'h3ffff, {2'b00, d});
      // narrow writes: 01h keeps the high byte, 31h takes only the high byte
      host.write_narrow(OP_WRSR_LOW, 16'hff00);
      expect_st(18'h3ffff, {2'b00, d[15:8], 8'h00});
      host.write_narrow(OP_WRSR_HIGH, 16'hff00);
      expect_st(18'h3ffff, 18'h0);
      $display("test fields done");
      foreach (CASES[k]) begin
         host.write_status(CASES[k].sd);
         host.issue(OP_WREN, 16'h0, '0);
         host.issue(OP_ERASE_4K, 16'h0, CASES[k].a);
         if (CASES[k].p) begin
            expect_st(18'h10003, 18'h10000);
         end else begin
            addr_q.push_back({OP_ERASE_4K, CASES[k].a & 21'h1ff000, CASES[k].a | 21'h000fff});
            fail_next = 1'($urandom());
            expect_st(18'h10001, 18'h00001);
            // suspend is heard only while the operation runs; resume at any time
            host.issue(OP_SUSPEND, 16'h0, '0);
            expect_st(18'h00800, 18'h00800);
            host.issue(OP_RESUME, 16'h0, '0);
            expect_st(18'h00800, 18'h0);
            wait_idle();
            expect_st(18'h08001, {2'b00, fail_next, 15'h0});
         end
      end
      $display("test decode done");
      host.issue(OP_FOUR_WIRE_ON, 16'h0, '0);
      expect_st(18'h20000, 18'h0);
      // pin driven by the bench, so quad may be set
      host.write_status(16'h0200);
      host.issue(OP_FOUR_WIRE_ON, 16'h0, '0);
      expect_st(18'h20200, 18'h20200);
      host.write_status(16'h0000);
      expect_st(18'h20200, 18'h20200);
      host.issue(OP_FOUR_WIRE_OFF, 16'h0, '0);
      host.write_status(16'h0000);
      expect_st(18'h20200, 18'h0);
      $display("test quad done");
      host.write_status(16'h0080);
      write_protect_n = 0;
      host.write_status(16'h0084);
      // the fail flag keeps the outcome of the last finished erase
      expect_st(18'h0ffff, {2'b00, fail_next, 15'h0080});
      write_protect_n = 1;
      host.write_status(16'h0000);
      expect_st(18'h0ffff, {2'b00, fail_next, 15'h0000});
      write_protect_n = 0;
      host.write_status(16'h0004);
      expect_st(18'h0ffff, {2'b00, fail_next, 15'h0004});
      write_protect_n = 1;
      host.write_status(16'h0100);
      host.write_status(16'h0008);
      expect_st(18'h0ffff, {2'b00, fail_next, 15'h0100});
      host.issue(OP_SUSPEND, 16'h0, '0);
      power_cycle(16'h0904);
      expect_st(18'h0ffff, 18'h0004);
      host.write_status(16'h0400);
      host.write_status(16'h0000);
      expect_st(18'h0ffff, 18'h0400);
      host.write_status(16'h0580);
      write_protect_n = 0;
      host.write_status(16'h0000);
      expect_st(18'h0ffff, 18'h0580);
      $display("test locks done");
      stop_test();
   end
endmodule

//--- sim/fsp_protect_properties.sv
// ==========================================================
// protection checker, link domain only
module fsp_protect_chk (
   input wire logic lnk_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic write_protect_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic nv_load,
   input wire logic [15:0] status_word,
   input wire logic [1:0] drive_strength,
   input wire logic quad_pins_enable,
   input wire logic four_wire_command_mode,
   input wire logic security_regs_locked,
   input wire logic op_refused
);
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   default clocking cb @(posedge lnk_clk);
   endclocking
   default disable iff (!rst_n);
   logic take;
   logic wr;
   // instruction taken on this edge; nv_load wins a tie
   assign take = cmd_valid && clk_en && !nv_load;
   assign wr = take && (cmd_code == OP_WRSR_LOW || cmd_code == OP_WRSR_HIGH);
   strength_mirror_a: assert property (drive_strength == status_word[14:13])
      else $error("drive strength differs from status");
   pins_mirror_a: assert property (quad_pins_enable == status_word[9])
      else $error("quad pin enable differs from status");
   lock_sticky_a: assert property (
      status_word[10] && !nv_load |=> status_word[10] && security_regs_locked)
      else $error("security lock dropped");
   range_hold_a: assert property (
      !nv_load && !wr |=> $stable(status_word[6:2]) && $stable(status_word[12]))
      else $error("protect bits changed without a status write");
   otp_hold_a: assert property (
      status_word[8:7] == LOCK_OTP && !nv_load
      |=> $stable(status_word[10:2]) && $stable(status_word[14:12]))
      else $error("status changed under permanent lock");
   power_hold_a: assert property (
      status_word[8:7] == LOCK_POWER && !nv_load
      |=> $stable(status_word[10:2]) && $stable(status_word[14:12]))
      else $error("status changed under power lock");
   pin_hold_a: assert property (
      !write_protect_n [*4] ##0 (status_word[8:7] == LOCK_PIN && !status_word[9] && !nv_load)
      |=> $stable(status_word[10:2]))
      else $error("status changed while pin lock held");
   refuse_flags_a: assert property (
      op_refused |-> !status_word[1] && $stable(status_word[15]))
      else $error("refusal left enable latch or touched fail flag");
   quad_gate_a: assert property (
      $rose(four_wire_command_mode) |-> $past(status_word[9]))
      else $error("four wire mode entered without quad bit");
   quad_keep_a: assert property (four_wire_command_mode |-> status_word[9])
      else $error("quad bit low in four wire mode");
   // suspend only means something while an operation runs; idle it is ignored
   pause_set_a: assert property (
      take && status_word[0] && cmd_code == OP_SUSPEND |=> status_word[11])
      else $error("suspend did not set paused flag");
   pause_clear_a: assert property (take && cmd_code == OP_RESUME |=> !status_word[11])
      else $error("resume did not clear paused flag");
   cover property (op_refused);
   cover property (four_wire_command_mode);
   cover property (status_word[8:7] == LOCK_OTP);
   cover property (status_word[11] && status_word[0]);
endmodule

bind fsp_protect fsp_protect_chk chk_i (.lnk_clk, .rst_n, .clk_en, .write_protect_n, .cmd_valid,
   .cmd_code, .nv_load, .status_word, .drive_strength, .quad_pins_enable,
   .four_wire_command_mode, .security_regs_locked, .op_refused);
